// >>> core/acs_regs.svh
// constants of the conversion output sequencer
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

`define ACS_WORD_W      12
`define ACS_MAX_CH      4
`define ACS_LATENCY     5
`define ACS_MARK_BASE   7
`define ACS_TOTAL_MSPS  6
`define ACS_WARM_W      4
`define ACS_ZERO_WORD   12'h000

`endif

// >>> core/acs_pkg.sv
// types of the conversion output sequencer
`default_nettype none
package acs_pkg;
  typedef enum logic {
    acs_warm,
    acs_run
  } acs_phase_type;

  typedef logic [11:0] acs_word_type;
  typedef logic [1:0]  acs_chan_type;
endpackage
`default_nettype wire

// >>> core/acs_word_if.sv
// carrier between sequencer and output coder
`timescale 1ns/1ps
`default_nettype none
interface acs_word_if;
  logic [11:0] raw;
  logic        twos;
  logic [11:0] coded;
  modport seq (output raw, output twos, input coded);
  modport fmt (input raw, input twos, output coded);
endinterface
`default_nettype wire

// >>> core/acs_format.sv
// output coder: offset binary or twos complement
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"
module acs_format
  import acs_pkg::*;
(
  acs_word_if.fmt port
);
  // -----------------------------
  // coding
  // -----------------------------
  always_comb begin
    port.coded = port.raw;
    if (port.twos) begin
      port.coded[`ACS_WORD_W-1] = ~port.raw[`ACS_WORD_W-1];
    end
  end
endmodule
`default_nettype wire

// >>> core/acs_sequencer.sv
// conversion pacing, result pipeline, channel sequence and read port
//
// How it works
// - each conversion-clock falling edge starts conversion
// - result appears five conversion clocks later
// - first marker after seven plus channels
// - marker low while channel one word out
// - single channel keeps marker high
// - channels delivered one to N, repeating
// - per-channel rate is six MSPS over N
// - fresh word each falling edge, host reads
// - read needs both selects plus read strobe
// - single-ended, differential or mixed configuration accepted
// - output binary or twos complement
// - single-ended binary codes FFF, 800, 000
// - single-ended twos codes 7FF, 000, 800
// - differential binary codes FFF, 800, 000
// - differential twos codes 7FF, 000, 800
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"
module acs_sequencer
  import acs_pkg::*;
#(
  parameter int WORD_W  = `ACS_WORD_W,
  parameter int MAX_CH  = `ACS_MAX_CH,
  parameter int LATENCY = `ACS_LATENCY
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic                     conversion_clock_in,
  input  wire logic                     select_low_n,
  input  wire logic                     select_high,
  input  wire logic                     read_n,
  input  wire logic                     scan_enable,
  input  wire logic [1:0]               channel_select,
  input  wire logic [1:0]               diff_select,
  input  wire logic                     twos_format,
  input  wire logic [MAX_CH*WORD_W-1:0] analog_code,
  output var  logic [WORD_W-1:0]        data_out,
  output var  logic                     data_oe,
  output var  logic                     frame_mark_n,
  output var  logic                     word_ready
);
  // -----------------------------
  // helpers
  // -----------------------------
  function automatic logic [2:0] chan_count(input logic scan, input logic [1:0] sel);
    chan_count = scan ? ({1'b0, sel} + 3'd1) : 3'd1;
  endfunction

  // -----------------------------
  // pin synchronisers
  // -----------------------------
  logic [1:0] sync_cclk;
  logic [1:0] sync_sel_lo;
  logic [1:0] sync_sel_hi;
  logic [1:0] sync_rd;
  logic [1:0] sync_scan;
  logic [3:0] sync_chsel;
  logic [3:0] sync_diff;
  logic [1:0] sync_twos;
  logic       cclk_prev;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_cclk   <= 2'h0;
      sync_sel_lo <= 2'h3;
      sync_sel_hi <= 2'h0;
      sync_rd     <= 2'h3;
      sync_scan   <= 2'h0;
      sync_chsel  <= 4'h0;
      sync_diff   <= 4'h0;
      sync_twos   <= 2'h0;
      cclk_prev   <= 1'b0;
    end else begin
      sync_cclk   <= {sync_cclk[0], conversion_clock_in};
      sync_sel_lo <= {sync_sel_lo[0], select_low_n};
      sync_sel_hi <= {sync_sel_hi[0], select_high};
      sync_rd     <= {sync_rd[0], read_n};
      sync_scan   <= {sync_scan[0], scan_enable};
      sync_chsel  <= {sync_chsel[1:0], channel_select};
      sync_diff   <= {sync_diff[1:0], diff_select};
      sync_twos   <= {sync_twos[0], twos_format};
      cclk_prev   <= sync_cclk[1];
    end
  end

  logic       conv_start;
  logic [2:0] n_chan;
  logic [5:0] cfg_now;
  logic       qualified_read;

  assign conv_start     = cclk_prev & ~sync_cclk[1];
  assign n_chan         = chan_count(sync_scan[1], sync_chsel[3:2]);
  assign cfg_now        = {sync_scan[1], sync_chsel[3:2], sync_diff[3:2], 1'b0};
  assign qualified_read = ~sync_sel_lo[1] & sync_sel_hi[1] & ~sync_rd[1];

  // -----------------------------
  // sequence state
  // -----------------------------
  acs_phase_type              phase;
  acs_phase_type              next_phase;
  acs_chan_type               chan_idx;
  acs_chan_type               next_chan_idx;
  logic [`ACS_WARM_W-1:0]     warm_cnt;
  logic [`ACS_WARM_W-1:0]     next_warm_cnt;
  logic [5:0]                 cfg_seen;
  logic                       cfg_change;
  logic [`ACS_WARM_W-1:0]     mark_delay;

  assign cfg_change = (cfg_now != cfg_seen);
  assign mark_delay = `ACS_WARM_W'(`ACS_MARK_BASE) + `ACS_WARM_W'(n_chan);

  always_comb begin
    next_phase    = phase;
    next_chan_idx = chan_idx;
    next_warm_cnt = warm_cnt;
    case (phase)
      acs_warm: begin
        if (conv_start) begin
          next_warm_cnt = warm_cnt + `ACS_WARM_W'(1);
          if (next_warm_cnt >= mark_delay) begin
            next_phase = acs_run;
          end
        end
      end
      acs_run: begin
        next_phase = acs_run;
      end
      default: begin
        next_phase = acs_warm;
      end
    endcase
    if (conv_start) begin
      if ({1'b0, chan_idx} + 3'd1 >= n_chan) begin
        next_chan_idx = 2'h0;
      end else begin
        next_chan_idx = chan_idx + 2'h1;
      end
    end
    if (cfg_change) begin
      next_phase    = acs_warm;
      next_chan_idx = 2'h0;
      next_warm_cnt = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase    <= acs_warm;
      chan_idx <= 2'h0;
      warm_cnt <= '0;
      cfg_seen <= '0;
    end else begin
      phase    <= next_phase;
      chan_idx <= next_chan_idx;
      warm_cnt <= next_warm_cnt;
      cfg_seen <= cfg_now;
    end
  end

  // -----------------------------
  // result pipeline
  // -----------------------------
  acs_word_type pipe_word [LATENCY];
  acs_chan_type pipe_chan [LATENCY];
  acs_word_type next_pipe_word [LATENCY];
  acs_chan_type next_pipe_chan [LATENCY];
  acs_word_type sample_word;

  always_comb begin
    sample_word = analog_code[chan_idx*WORD_W +: WORD_W];
    for (int i = 0; i < LATENCY; i++) begin
      next_pipe_word[i] = pipe_word[i];
      next_pipe_chan[i] = pipe_chan[i];
    end
    if (conv_start) begin
      next_pipe_word[0] = sample_word;
      next_pipe_chan[0] = chan_idx;
      for (int i = 1; i < LATENCY; i++) begin
        next_pipe_word[i] = pipe_word[i-1];
        next_pipe_chan[i] = pipe_chan[i-1];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe_word[i] <= `ACS_ZERO_WORD;
        pipe_chan[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe_word[i] <= next_pipe_word[i];
        pipe_chan[i] <= next_pipe_chan[i];
      end
    end
  end

  // -----------------------------
  // output coding
  // -----------------------------
  acs_word_if coder ();

  assign coder.raw  = pipe_word[LATENCY-1];
  assign coder.twos = sync_twos[1];

  acs_format u_format (
    .port (coder.fmt)
  );

  // -----------------------------
  // output registers
  // -----------------------------
  acs_word_type next_data_out;
  logic         next_data_oe;
  logic         next_frame_mark_n;
  logic         next_word_ready;

  // word leaving the last stage is latched as the next conversion starts
  always_comb begin
    next_data_out     = data_out;
    next_data_oe      = qualified_read;
    next_word_ready   = conv_start;
    next_frame_mark_n = frame_mark_n;
    if (conv_start) begin
      next_data_out     = coder.coded;
      next_frame_mark_n = 1'b1;
      if (n_chan > 3'h1 && phase == acs_run && pipe_chan[LATENCY-1] == 2'h0) begin
        next_frame_mark_n = 1'b0;
      end
    end
    if (n_chan == 3'h1 || cfg_change) begin
      next_frame_mark_n = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      data_out     <= `ACS_ZERO_WORD;
      data_oe      <= 1'b0;
      frame_mark_n <= 1'b1;
      word_ready   <= 1'b0;
    end else begin
      data_out     <= next_data_out;
      data_oe      <= next_data_oe;
      frame_mark_n <= next_frame_mark_n;
      word_ready   <= next_word_ready;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/acs_sequencer_chk.sv
// port assertions for the conversion output sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic conversion_clock_in,
  input wire logic select_low_n,
  input wire logic select_high,
  input wire logic read_n,
  input wire logic scan_enable,
  input wire logic data_oe,
  input wire logic frame_mark_n,
  input wire logic word_ready
);
  logic qual;
  assign qual = !select_low_n && select_high && !read_n;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  start_word_a: assert property ($fell(conversion_clock_in) |-> ##[3:5] word_ready)
    else $error("no word after start");
  word_cause_a: assert property (word_ready |-> !$past(conversion_clock_in, 3))
    else $error("word without start");
  word_pulse_a: assert property (word_ready |=> !word_ready [*4])
    else $error("word pulse too long");
  read_grant_a: assert property (qual [*3] |=> data_oe)
    else $error("read not granted");
  read_refuse_a: assert property ((!qual) [*3] |=> !data_oe)
    else $error("bus driven without read");
  read_hold_a: assert property (qual [*4] ##1 !qual |-> data_oe [*3])
    else $error("bus released early");
  single_mark_a: assert property ((!scan_enable) [*6] |-> frame_mark_n)
    else $error("marker in single mode");
  mark_fall_a: assert property ($fell(frame_mark_n) |-> word_ready)
    else $error("marker without word");
endmodule
bind acs_sequencer acs_sequencer_chk i_chk (.ref_clk, .rst, .conversion_clock_in, .select_low_n,
  .select_high, .read_n, .scan_enable, .data_oe, .frame_mark_n, .word_ready);
`default_nettype wire

// >>> testbench/acs_host_model.sv
// host model: conversion clock source and reader
`timescale 1ns/1ps
`default_nettype none
module acs_host_model (
  input  wire logic ref_clk,
  input  wire logic run,
  input  wire logic bad_sel,
  output var  logic conversion_clock_in,
  output var  logic select_low_n,
  output var  logic select_high,
  output var  logic read_n
);
  logic [2:0] phase = 3'h0;
  initial begin
    conversion_clock_in = 1'b1;
    select_low_n = 1'b1;
    select_high = 1'b0;
    read_n = 1'b1;
  end
  // clock idles high when stopped
  always @(negedge ref_clk) begin
    phase <= run ? phase + 3'h1 : 3'h0;
    conversion_clock_in <= !(run && phase[2]);
    read_n <= !(run && phase[2]);
    select_low_n <= bad_sel;
    select_high <= 1'b1;
  end
endmodule
`default_nettype wire

// >>> testbench/acs_sequencer_tb.sv
// self-checking bench for the conversion output sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_tb;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        run = 1'b0;
  logic        bad_sel = 1'b0;
  logic        scan_enable = 1'b0;
  logic [1:0]  channel_select = 2'h0;
  logic [1:0]  diff_select = 2'h0;
  logic        twos_format = 1'b0;
  logic [47:0] analog_code = 48'h123_000_800_fff;
  logic        conversion_clock_in, select_low_n, select_high, read_n;
  logic        data_oe, frame_mark_n, word_ready;
  logic [11:0] data_out;
  int          fail_count = 0;
  int          checks = 0;
  int          cycles = 0;
  always #50 ref_clk = ~ref_clk;
  acs_sequencer i_dut (.ref_clk, .rst, .conversion_clock_in, .select_low_n, .select_high, .read_n,
    .scan_enable, .channel_select, .diff_select, .twos_format, .analog_code, .data_out, .data_oe,
    .frame_mark_n, .word_ready);
  acs_host_model i_host (.ref_clk, .run, .bad_sel, .conversion_clock_in, .select_low_n, .select_high,
    .read_n);
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // waits for the next word, samples it once settled
  task automatic next_word(output logic [11:0] d, output logic m, output logic oe);
    int k = 0;
    while (word_ready !== 1'b1 && k < 40) begin
      @(negedge ref_clk);
      k++;
    end
    @(negedge ref_clk);
    d = data_out;
    m = frame_mark_n;
    oe = data_oe;
    chk(12'(k < 40), 12'h1, "word timeout");
  endtask
  task automatic restart(input logic sc, input int n, input logic tw, input logic [1:0] df);
    run <= 1'b0;
    repeat (12) @(negedge ref_clk);
    scan_enable = sc;
    channel_select = 2'(n - 1);
    diff_select = df;
    twos_format = tw;
    repeat (6) @(negedge ref_clk);
    run <= 1'b1;
  endtask
  task automatic t_multi(input int n, input logic tw, input logic [1:0] df);
    logic [11:0] d;
    logic m, oe;
    int first = 0;
    restart(1'b1, n, tw, df);
    for (int i = 1; i <= 8 + 2 * n && first == 0; i++) begin
      next_word(d, m, oe);
      if (m === 1'b0) first = i;
    end
    chk(12'(first >= 7 + n), 12'h1, "first marker");
    for (int j = 1; j <= 2 * n; j++) begin
      next_word(d, m, oe);
      chk(d, analog_code[(j % n) * 12 +: 12] ^ {tw, 11'h0}, "word");
      chk({11'h0, m}, 12'(j % n != 0), "marker");
      chk({11'h0, oe}, 12'h1, "bus drive");
    end
    $display("multi %0d done", n);
  endtask
  task automatic t_single(input logic tw, input logic mode_bad);
    logic [11:0] d;
    logic m, oe;
    bad_sel <= mode_bad;
    restart(1'b0, 1, tw, 2'h0);
    for (int i = 1; i <= 12; i++) begin
      next_word(d, m, oe);
      chk({11'h0, m}, 12'h1, "single marker");
      if (i > 6) chk(d, analog_code[11:0] ^ {tw, 11'h0}, "single word");
      if (i > 2) chk({11'h0, oe}, 12'(!mode_bad), "bus drive");
    end
    $display("single %0d %0d done", tw, mode_bad);
  endtask
  // new code enters at the next start and leaves five starts later
  task automatic t_latency();
    logic [11:0] d;
    logic m, oe;
    next_word(d, m, oe);
    analog_code[11:0] = 12'h5a5;
    for (int k = 1; k <= 6; k++) begin
      next_word(d, m, oe);
      chk(d, (k < 6) ? 12'hfff : 12'h5a5, "latency");
    end
    $display("latency done");
  endtask
  initial begin
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    t_multi(2, 1'b0, 2'h0);
    t_multi(3, 1'b1, 2'h1);
    t_multi(4, 1'b1, 2'h0);
    t_multi(2, 1'b0, 2'h2);
    t_single(1'b0, 1'b0);
    t_single(1'b1, 1'b0);
    t_single(1'b0, 1'b1);
    t_latency();
    report_and_stop();
  end
endmodule
`default_nettype wire
